// ---- design/fdpt_params.svh ----
`ifndef FDPT_PARAMS_SVH
`define FDPT_PARAMS_SVH

// discovery read opcode and filler byte
`define FDPT_CMD_READ_TABLE   8'h5A
`define FDPT_BLANK_BYTE       8'hFF

// header fields of the two table entries
`define FDPT_HDR_COUNT        8'h01
`define FDPT_REV_MINOR        8'h00
`define FDPT_REV_MAJOR        8'h01
`define FDPT_STD_ID           8'h00
`define FDPT_STD_PTR          8'h30
`define FDPT_STD_LEN          8'h09
`define FDPT_VND_PTR          8'h60
`define FDPT_VND_LEN          8'h04

// register byte offsets
`define FDPT_REG_CTRL         8'h00
`define FDPT_REG_STATUS       8'h04
`define FDPT_REG_FRAMES       8'h08
`define FDPT_REG_PEEK_ADDR    8'h0C
`define FDPT_REG_PEEK_DATA    8'h10

// field positions
`define FDPT_CTRL_EN_BIT      0
`define FDPT_STAT_BUSY_BIT    0
`define FDPT_STAT_STREAM_BIT  1
`define FDPT_STAT_BADCMD_BIT  2
`define FDPT_STAT_STATE_LSB   4
`define FDPT_STAT_ADDR_LSB    8

// reset values
`define FDPT_CTRL_EN_RST      1'b1
`define FDPT_OUT_RST          8'hFF

// avalon response codes
`define FDPT_RESP_OKAY        2'h0
`define FDPT_RESP_SLVERR      2'h2

`endif

// ---- design/fdpt_pkg.sv ----
package fdpt_pkg;

   // serial frame sequencer states
   typedef enum logic [2:0] {
      FDPT_IDLE   = 3'h0,
      FDPT_OPCODE = 3'h1,
      FDPT_ADDR   = 3'h2,
      FDPT_DUMMY  = 3'h3,
      FDPT_DATA   = 3'h4,
      FDPT_IGNORE = 3'h5
   } fdpt_state_t;

endpackage

// ---- design/fdpt_table_rom.sv ----
`timescale 1ns/1ps
`include "fdpt_params.svh"

module fdpt_table_rom #(
   parameter logic [7:0] VENDOR_ID = 8'hA5  // arbitrary value
) (
   // lookup
   input  wire logic [23:0] addr,
   output logic      [7:0]  data
);

   // fixed table contents, blank filler elsewhere
   always_comb
   begin
      case (addr)
         24'h000006: data = `FDPT_HDR_COUNT;
         24'h000008: data = `FDPT_STD_ID;
         24'h000009: data = `FDPT_REV_MINOR;
         24'h00000A: data = `FDPT_REV_MAJOR;
         24'h00000B: data = `FDPT_STD_LEN;
         24'h00000C: data = `FDPT_STD_PTR;
         24'h00000D: data = 8'h00;
         24'h00000E: data = 8'h00;
         24'h000010: data = VENDOR_ID;
         24'h000011: data = `FDPT_REV_MINOR;
         24'h000012: data = `FDPT_REV_MAJOR;
         24'h000013: data = `FDPT_VND_LEN;
         24'h000014: data = `FDPT_VND_PTR;
         24'h000015: data = 8'h00;
         24'h000016: data = 8'h00;
         24'h000030: data = 8'hE5;
         24'h000031: data = 8'h20;
         24'h000032: data = 8'hF1;
         24'h000037: data = 8'h01;
         24'h000038: data = 8'h44;
         24'h000039: data = 8'hEB;
         24'h00003A: data = 8'h08;
         24'h00003B: data = 8'h6B;
         24'h00003C: data = 8'h08;
         24'h00003D: data = 8'h3B;
         24'h00003E: data = 8'h04;
         24'h00003F: data = 8'hBB;
         24'h000040: data = 8'hEE;
         24'h000046: data = 8'h00;
         24'h00004A: data = 8'h00;
         24'h00004C: data = 8'h0C;
         24'h00004D: data = 8'h20;
         24'h00004E: data = 8'h0F;
         24'h00004F: data = 8'h52;
         24'h000050: data = 8'h10;
         24'h000051: data = 8'hD8;
         24'h000052: data = 8'h00;
         24'h000060: data = 8'h00;
         24'h000061: data = 8'h36;
         24'h000062: data = 8'h00;
         24'h000063: data = 8'h17;
         24'h000064: data = 8'h9D;
         24'h000065: data = 8'hF9;
         24'h000067: data = 8'h64;
         24'h000068: data = 8'hFE;
         24'h000069: data = 8'hCF;
         default:    data = `FDPT_BLANK_BYTE;
      endcase
   end

endmodule // fdpt_table_rom

// ---- design/flash_discovery_param_table.sv ----
// Contract
// - opcode, three address bytes, dummy, then stream
// - header points at 30h, nine words
// - byte 30h bits 1:0 read 01b
// - byte 30h bit 2 reads one
// - byte 30h bits 4:3 read zero
// - byte 30h bits 7:5 fixed, reads E5h
// - byte 32h reads F1h
// - address width field reads 00b
// - 1-4-4 read: 44h then EBh
// - 1-1-4 read: 08h then 6Bh
// - 1-1-2 read: 08h at 3Ch, 3Bh
// - 1-2-2 read: 04h then BBh
// - 2-2-2, 4-4-4 declared unsupported
// - erase type one: 0Ch, opcode 20h
// - erase types two to four sizes, opcodes
// - supply range bytes 00 36 00 17
// - feature half-word reads F99Dh
// - wrap length byte 67h reads 64h
// - lock feature word reads CFFEh
// - unused locations read FFh
// - wait states are dummy clocks
`timescale 1ns/1ps
`include "fdpt_params.svh"

module flash_discovery_param_table
   import fdpt_pkg::*;
#(
   parameter int         ADDR_BYTES = 3,
   parameter logic [7:0] VENDOR_ID  = 8'hA5  // arbitrary value
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // serial flash pins
   input  wire logic        sclk,
   input  wire logic        csN,
   input  wire logic        si,
   output logic             soOut,
   output logic             soOeN,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic      [1:0]  avs_response,
   output logic             avs_waitrequest
);

   // parameters the sequencer cannot serve, refused at elaboration
   if (ADDR_BYTES < 1 || ADDR_BYTES > 3)
   begin : gBadAddrBytes
      $error("ADDR_BYTES must lie between 1 and 3");
   end

   // reset release synchroniser
   logic [1:0] rstSyncQ;
   logic       rstN;

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         rstSyncQ <= 2'h0;
      else
         rstSyncQ <= {rstSyncQ[0], 1'b1};
   end

   assign rstN = rstSyncQ[1];

   // pin synchronisers and clock edge history
   logic [2:0] pinMetaQ, pinMetaD;  // {sclk, csN, si} first stage
   logic [2:0] pinSyncQ, pinSyncD;  // second stage
   logic       sclkPrevQ, sclkPrevD;
   logic       sclkRise, sclkFall, selected, siBit;

   always_comb
   begin
      pinMetaD  = {sclk, csN, si};
      pinSyncD  = pinMetaQ;
      sclkPrevD = pinSyncQ[2];
   end

   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         pinMetaQ  <= 3'h2;
         pinSyncQ  <= 3'h2;
         sclkPrevQ <= 1'b0;
      end
      else
      begin
         pinMetaQ  <= pinMetaD;
         pinSyncQ  <= pinSyncD;
         sclkPrevQ <= sclkPrevD;
      end
   end

   // edge and level decode on the second stage only
   assign sclkRise = pinSyncQ[2] & ~sclkPrevQ;
   assign sclkFall = ~pinSyncQ[2] & sclkPrevQ;
   assign selected = ~pinSyncQ[1];
   assign siBit    = pinSyncQ[0];

   // register decode shared by read and write paths
   function automatic logic fdptIsMapped(input logic [7:0] a);
      fdptIsMapped = (a == `FDPT_REG_CTRL)      || (a == `FDPT_REG_STATUS) ||
                     (a == `FDPT_REG_FRAMES)    || (a == `FDPT_REG_PEEK_ADDR) ||
                     (a == `FDPT_REG_PEEK_DATA);
   endfunction

   // sequencer state
   fdpt_state_t stateQ, stateD;
   logic [2:0]  bitCntQ, bitCntD;
   logic [1:0]  byteCntQ, byteCntD;
   logic [7:0]  shInQ, shInD;
   logic [7:0]  shOutQ, shOutD;
   logic [23:0] addrQ, addrD;
   logic        pendQ, pendD;
   logic        badCmdQ, badCmdD;
   logic [15:0] framesQ, framesD;
   logic [7:0]  inByte;
   logic [23:0] romAddr;
   logic [7:0]  romData;

   // register file state
   logic        enableQ, enableD;
   logic [23:0] peekAddrQ, peekAddrD;
   logic [7:0]  peekData;
   logic        ackQ, ackD;
   logic [31:0] rdataQ, rdataD;
   logic [1:0]  respQ, respD;
   logic        reqActive, wrTake, badCmdClr;

   // table lookups for the stream and for software peeks
   assign romAddr = (stateQ == FDPT_DATA) ? addrQ + 24'h1 : addrQ;

   fdpt_table_rom #(
      .VENDOR_ID (VENDOR_ID)
   ) uStreamRom (
      .addr      (romAddr),
      .data      (romData)
   );

   fdpt_table_rom #(
      .VENDOR_ID (VENDOR_ID)
   ) uPeekRom (
      .addr      (peekAddrQ),
      .data      (peekData)
   );

   // byte assembled on this rising edge
   assign inByte = {shInQ[6:0], siBit};

   // frame sequencer next state
   always_comb
   begin
      stateD   = stateQ;
      bitCntD  = bitCntQ;
      byteCntD = byteCntQ;
      shInD    = shInQ;
      shOutD   = shOutQ;
      addrD    = addrQ;
      pendD    = pendQ;
      framesD  = framesQ;
      badCmdD  = badCmdQ & ~badCmdClr;
      if (!selected)
      begin
         // deselect ends any frame at once
         stateD = FDPT_IDLE;
         pendD  = 1'b0;
         shOutD = `FDPT_OUT_RST;
         if (stateQ == FDPT_DATA)
            framesD = framesQ + 16'h1;
      end
      else
      begin
         case (stateQ)
            FDPT_IDLE:
            begin
               bitCntD  = 3'h0;
               byteCntD = 2'h0;
               stateD   = enableQ ? FDPT_OPCODE : FDPT_IGNORE;
            end
            FDPT_OPCODE, FDPT_ADDR, FDPT_DUMMY:
            begin
               if (sclkRise)
               begin
                  // shift input MSB first
                  shInD   = inByte;
                  bitCntD = bitCntQ + 3'h1;
                  if (bitCntQ == 3'h7)
                  begin
                     if (stateQ == FDPT_OPCODE)
                     begin
                        if (inByte == `FDPT_CMD_READ_TABLE)
                           stateD = FDPT_ADDR;
                        else
                        begin
                           stateD  = FDPT_IGNORE;
                           badCmdD = 1'b1;  // set wins over clear
                        end
                     end
                     else if (stateQ == FDPT_ADDR)
                     begin
                        addrD    = {addrQ[15:0], inByte};
                        byteCntD = byteCntQ + 2'h1;
                        if (byteCntQ == 2'(ADDR_BYTES - 1))
                           stateD = FDPT_DUMMY;
                     end
                     else
                     begin
                        // dummy byte done, first data byte ready
                        stateD = FDPT_DATA;
                        shOutD = romData;
                        pendD  = 1'b0;
                     end
                  end
               end
            end
            FDPT_DATA:
            begin
               if (sclkRise)
               begin
                  // host sampled a bit
                  pendD   = 1'b1;
                  bitCntD = bitCntQ + 3'h1;
               end
               else if (sclkFall && pendQ)
               begin
                  pendD = 1'b0;
                  if (bitCntQ == 3'h0)
                  begin
                     // next table byte, address advances
                     addrD  = addrQ + 24'h1;
                     shOutD = romData;
                  end
                  else
                     shOutD = {shOutQ[6:0], 1'b1};
               end
            end
            FDPT_IGNORE:
               stateD = FDPT_IGNORE;
            default:
               stateD = FDPT_IDLE;
         endcase
      end
   end

   // frame sequencer registers
   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         stateQ   <= FDPT_IDLE;
         bitCntQ  <= 3'h0;
         byteCntQ <= 2'h0;
         shInQ    <= 8'h00;
         shOutQ   <= `FDPT_OUT_RST;
         addrQ    <= 24'h000000;
         pendQ    <= 1'b0;
         badCmdQ  <= 1'b0;
         framesQ  <= 16'h0000;
      end
      else
      begin
         stateQ   <= stateD;
         bitCntQ  <= bitCntD;
         byteCntQ <= byteCntD;
         shInQ    <= shInD;
         shOutQ   <= shOutD;
         addrQ    <= addrD;
         pendQ    <= pendD;
         badCmdQ  <= badCmdD;
         framesQ  <= framesD;
      end
   end

   // serial output, driven only while streaming
   assign soOut = shOutQ[7];
   assign soOeN = (stateQ != FDPT_DATA);

   // bus handshake: one wait cycle, then answer
   assign reqActive       = avs_read | avs_write;
   assign avs_waitrequest = reqActive & ~ackQ;
   assign wrTake          = avs_write & ackQ;
   assign badCmdClr       = wrTake && (avs_address == `FDPT_REG_STATUS) &&
                            avs_byteenable[0] && avs_writedata[`FDPT_STAT_BADCMD_BIT];
   assign avs_readdata    = rdataQ;
   assign avs_response    = respQ;

   // register file next state
   always_comb
   begin
      ackD      = reqActive & ~ackQ;
      rdataD    = rdataQ;
      respD     = respQ;
      enableD   = enableQ;
      peekAddrD = peekAddrQ;
      if (reqActive && !ackQ)
      begin
         respD  = fdptIsMapped(avs_address) ? `FDPT_RESP_OKAY : `FDPT_RESP_SLVERR;
         rdataD = 32'h0;
         if (avs_read)
         begin
            case (avs_address)
               `FDPT_REG_CTRL:
                  rdataD[`FDPT_CTRL_EN_BIT] = enableQ;
               `FDPT_REG_STATUS:
               begin
                  rdataD[`FDPT_STAT_BUSY_BIT]   = selected;
                  rdataD[`FDPT_STAT_STREAM_BIT] = (stateQ == FDPT_DATA);
                  rdataD[`FDPT_STAT_BADCMD_BIT] = badCmdQ;
                  rdataD[`FDPT_STAT_STATE_LSB +: 3] = stateQ;
                  rdataD[`FDPT_STAT_ADDR_LSB +: 24] = addrQ;
               end
               `FDPT_REG_FRAMES:
                  rdataD[15:0] = framesQ;
               `FDPT_REG_PEEK_ADDR:
                  rdataD[23:0] = peekAddrQ;
               `FDPT_REG_PEEK_DATA:
                  rdataD[7:0] = peekData;
               default:
                  rdataD = 32'h0;
            endcase
         end
      end
      if (wrTake && fdptIsMapped(avs_address))
      begin
         if (avs_address == `FDPT_REG_CTRL && avs_byteenable[0])
            enableD = avs_writedata[`FDPT_CTRL_EN_BIT];
         if (avs_address == `FDPT_REG_PEEK_ADDR)
         begin
            // byte lanes of the peek address
            for (int b = 0; b < 3; b++)
            begin
               if (avs_byteenable[b])
                  peekAddrD[8*b +: 8] = avs_writedata[8*b +: 8];
            end
         end
      end
   end

   // register file registers
   always_ff @(posedge sys_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         ackQ      <= 1'b0;
         rdataQ    <= 32'h0;
         respQ     <= `FDPT_RESP_OKAY;
         enableQ   <= `FDPT_CTRL_EN_RST;
         peekAddrQ <= 24'h000000;
      end
      else
      begin
         ackQ      <= ackD;
         rdataQ    <= rdataD;
         respQ     <= respD;
         enableQ   <= enableD;
         peekAddrQ <= peekAddrD;
      end
   end

endmodule // flash_discovery_param_table

// ---- test/fdpt_checker_assertions.sv ----
`timescale 1ns/1ps
`include "fdpt_params.svh"

module fdpt_checker (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rstn,
   // serial pins
   input wire logic        sclk,
   input wire logic        csN,
   input wire logic        soOut,
   input wire logic        soOeN,
   // register bus
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic [1:0]  avs_response,
   input wire logic        avs_waitrequest
);
   logic req;
   logic done;
   logic mapped;

   // bus request decode
   assign req    = avs_read | avs_write;
   assign done   = req & ~avs_waitrequest;
   assign mapped = avs_address inside {`FDPT_REG_CTRL, `FDPT_REG_STATUS, `FDPT_REG_FRAMES,
                                       `FDPT_REG_PEEK_ADDR, `FDPT_REG_PEEK_DATA};

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_wait_bounded: assert property (req && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
      else $error("bus request not answered in time");
   a_idle_no_wait: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest without a request");
   a_unmapped_error: assert property (done && !mapped |->
      avs_response == `FDPT_RESP_SLVERR && (avs_write || avs_readdata == 32'h0))
      else $error("unmapped access not refused");
   a_mapped_okay: assert property (done && mapped |-> avs_response == `FDPT_RESP_OKAY)
      else $error("mapped access not okay");
   a_peek_width: assert property (done && avs_read && avs_address == `FDPT_REG_PEEK_DATA
      |-> avs_readdata[31:8] == 24'h0)
      else $error("peek data wider than a byte");
   a_frames_width: assert property (done && avs_read && avs_address == `FDPT_REG_FRAMES
      |-> avs_readdata[31:16] == 16'h0)
      else $error("frame count wider than 16 bits");
   a_so_release: assert property (csN [*5] |-> soOeN)
      else $error("output still driven after deselect");
   a_oe_selected: assert property ($fell(soOeN) |-> !csN && !$past(csN, 8))
      else $error("output driven outside a frame");
   a_bit_on_low: assert property (!soOeN && $past(!soOeN) && $changed(soOut) |-> !sclk)
      else $error("output bit changed while serial clock high");
endmodule  // fdpt_checker

bind flash_discovery_param_table fdpt_checker i_chk (
   .sys_clk, .rstn, .sclk, .csN, .soOut, .soOeN, .avs_address, .avs_read,
   .avs_write, .avs_readdata, .avs_response, .avs_waitrequest);

// ---- test/fdpt_host_model.sv ----
`timescale 1ns/1ps

module fdpt_host_model #(
   parameter int HALF = 5
) (
   // system clock
   input wire logic sys_clk,
   // toward the device
   output logic     sclk,
   output logic     csN,
   output logic     si,
   // from the device
   input wire logic soOut,
   input wire logic soOeN
);
   logic [7:0] rxByte [0:63];
   logic       bitIn;
   int         oeBits;

   // idle: deselected, clock parked low
   initial
   begin
      sclk = 1'b0;
      csN  = 1'b1;
      si   = 1'b1;
   end

   // one clock: data set while low, output read just before the rise
   task automatic clk_bit(input logic b);
      si <= b;
      repeat (HALF) @(posedge sys_clk);
      @(negedge sys_clk);
      bitIn = (soOeN === 1'b0) ? soOut : 1'b1;  // released line floats high
      if (soOeN === 1'b0)
         oeBits++;
      @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
      sclk <= 1'b0;
   endtask

   // whole frame; cut above zero ends it after that many data bits
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n,
                        input int cut);
      logic [31:0] cmd;
      int          nb;
      cmd = {op, a};
      nb = (cut > 0) ? cut : n * 8;
      oeBits = 0;
      csN <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int i = 31; i >= 0; i--)
         clk_bit(cmd[i]);
      repeat (8) clk_bit(~si);  // dummy byte, no mode bits
      for (int i = 0; i < nb; i++)
      begin
         clk_bit(~si);
         rxByte[i / 8] = {rxByte[i / 8][6:0], bitIn};  // msb first
      end
      repeat (2) @(posedge sys_clk);
      csN <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule  // fdpt_host_model

// ---- test/test_flash_discovery_param_table.sv ----
`timescale 1ns/1ps
`include "fdpt_params.svh"

module test_flash_discovery_param_table;
   logic        sys_clk         = 1'b0;
   logic        rstn            = 1'b0;
   logic        sclk;
   logic        csN;
   logic        si;
   logic        soOut;
   logic        soOeN;
   logic [7:0]  avs_address     = 8'h00;
   logic        avs_read        = 1'b0;
   logic        avs_write       = 1'b0;
   logic [31:0] avs_writedata   = 32'h0;
   logic [3:0]  avs_byteenable  = 4'hF;
   logic [31:0] avs_readdata;
   logic [1:0]  avs_response;
   logic        avs_waitrequest;
   logic [31:0] rd;
   logic [1:0]  rs;
   int          fails           = 0;
   int          num_checks      = 0;

   // 10 MHz clock
   always #50 sys_clk = ~sys_clk;

   flash_discovery_param_table i_dut (
      .sys_clk, .rstn, .sclk, .csN, .si, .soOut, .soOeN, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_response,
      .avs_waitrequest);

   fdpt_host_model i_host (.sys_clk, .sclk, .csN, .si, .soOut, .soOeN);

   // expected table contents
   function automatic logic [7:0] exp_byte(input logic [7:0] a);
      case (a)
         8'h06, 8'h0A, 8'h37:                  return 8'h01;
         8'h08, 8'h09, 8'h0D, 8'h0E, 8'h46:    return 8'h00;
         8'h4A, 8'h52, 8'h60, 8'h62:           return 8'h00;
         8'h0B:                                return 8'h09;
         8'h0C:                                return 8'h30;
         8'h30:                                return 8'hE5;
         8'h31, 8'h4D:                         return 8'h20;
         8'h32:                                return 8'hF1;
         8'h38:                                return 8'h44;
         8'h39:                                return 8'hEB;
         8'h3A, 8'h3C:                         return 8'h08;
         8'h3B:                                return 8'h6B;
         8'h3D:                                return 8'h3B;
         8'h3E:                                return 8'h04;
         8'h3F:                                return 8'hBB;
         8'h40:                                return 8'hEE;
         8'h4C:                                return 8'h0C;
         8'h4E:                                return 8'h0F;
         8'h4F:                                return 8'h52;
         8'h50:                                return 8'h10;
         8'h51:                                return 8'hD8;
         8'h61:                                return 8'h36;
         8'h63:                                return 8'h17;
         8'h64:                                return 8'h9D;
         8'h65:                                return 8'hF9;
         8'h67:                                return 8'h64;
         8'h68:                                return 8'hFE;
         8'h69:                                return 8'hCF;
         default:                              return 8'hFF;
      endcase
   endfunction

   // compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one bus transfer, held until waitrequest is low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] be);
      avs_address    <= a;
      avs_write      <= wr;
      avs_read       <= !wr;
      avs_writedata  <= wd;
      avs_byteenable <= be;
      // sample the answer at the rising edge, take data there, then release
      do
         @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rs = avs_response;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask

   // register read and compare
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hF);
      check("register", rd, exp);
   endtask

   // stream compare against the expected table
   task automatic stream(input logic [7:0] a, input int n);
      i_host.frame(`FDPT_CMD_READ_TABLE, {16'h0, a}, n, 0);
      for (int i = 0; i < n; i++)
         check("table", i_host.rxByte[i], exp_byte(a + i[7:0]));
      check("driven bits", i_host.oeBits, n * 8);
   endtask

   // verdict
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard
   initial
   begin
      repeat (40000) @(posedge sys_clk);
      fails++;
      complete_run();
   end

   // main sequence
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rdchk(`FDPT_REG_CTRL, 32'h1);
      rdchk(`FDPT_REG_FRAMES, 32'h0);
      // header count and first entry, then both tables in one long stream
      stream(8'h06, 10);
      stream(8'h30, 64);
      rdchk(`FDPT_REG_FRAMES, 32'h2);
      // wrong opcode: never driven, sticky flag cleared by writing one
      i_host.frame(8'h0B, 24'h000030, 2, 0);
      check("driven bits", i_host.oeBits, 0);
      bus(1'b0, `FDPT_REG_STATUS, 32'h0, 4'hF);
      check("bad opcode", rd[2], 32'h1);
      bus(1'b1, `FDPT_REG_STATUS, 32'h4, 4'hF);
      bus(1'b0, `FDPT_REG_STATUS, 32'h0, 4'hF);
      check("bad opcode", rd[2], 32'h0);
      // disabled: frame ignored
      bus(1'b1, `FDPT_REG_CTRL, 32'h0, 4'hF);
      i_host.frame(`FDPT_CMD_READ_TABLE, 24'h000030, 2, 0);
      check("driven bits", i_host.oeBits, 0);
      bus(1'b1, `FDPT_REG_CTRL, 32'h1, 4'hF);
      // abort mid-byte, then a fresh frame
      i_host.frame(`FDPT_CMD_READ_TABLE, 24'h000032, 1, 3);
      check("driven bits", i_host.oeBits, 3);
      stream(8'h3C, 4);
      rdchk(`FDPT_REG_FRAMES, 32'h4);
      // peek through one byte lane
      bus(1'b1, `FDPT_REG_PEEK_ADDR, 32'h60, 4'hF);
      bus(1'b1, `FDPT_REG_PEEK_ADDR, 32'hFFFFFF65, 4'h1);
      rdchk(`FDPT_REG_PEEK_ADDR, 32'h65);
      rdchk(`FDPT_REG_PEEK_DATA, 32'hF9);
      bus(1'b1, `FDPT_REG_PEEK_ADDR, 32'h66, 4'hF);
      rdchk(`FDPT_REG_PEEK_DATA, 32'hFF);
      // unmapped place refused
      bus(1'b0, 8'h20, 32'h0, 4'hF);
      check("response", rs, `FDPT_RESP_SLVERR);
      check("unmapped data", rd, 32'h0);
      bus(1'b1, 8'h20, 32'h1, 4'hF);
      check("response", rs, `FDPT_RESP_SLVERR);
      complete_run();
   end
endmodule  // test_flash_discovery_param_table
